// [hw/hsrch_pkg.sv]
// constants, types and helpers of the home search error handler
//
// Summary of operation
// - drive fault in any step stops pulses at once, sets fault error and end cause
// - emergency stop in any step stops pulses at once, sets emergency bits
// - limit in index step stops instantly or decelerating, sets that limit's bits
// - limit in offset step ends it instantly or decelerating, sets limit bits
// - index already active at index step start ends search with index error
// - error summary bit is set whenever a search ends incorrectly
// - summary may read one during recovery with search direction limit active
// - a stuck limit blocks motion toward it and shows its limit error
// - near origin active at start with fast step enabled skips fast step
// - fast step hitting search limit stops there, slow step recovers irregularly
// - origin stuck active: move opposite until opposite limit, flag that limit
// - slow step at search limit reverses to opposite limit, flags that limit
// - index step at search limit stops and flags the search direction limit
// - index error clears on drive command, new search or status clear
// - driving bit is one from search start until any termination
// - decelerating or instant stop command aborts the search
package hsrch_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int HSRCH_AW = 5;
  localparam logic [4:0] HSRCH_CTRL_OFS = 5'h00;
  localparam logic [4:0] HSRCH_MODE_OFS = 5'h04;
  localparam logic [4:0] HSRCH_MAIN_OFS = 5'h08;
  localparam logic [4:0] HSRCH_ERR_OFS = 5'h0C;
  localparam logic [4:0] HSRCH_END_OFS = 5'h10;
  // command bits of the control register, write only
  localparam int CTRL_START = 0;
  localparam int CTRL_DSTOP = 1;
  localparam int CTRL_ISTOP = 2;
  localparam int CTRL_CLR = 3;
  localparam int CTRL_DRIVE = 4;
  // mode: enable of step k at 2k-2, direction (1 = minus) at 2k-1
  localparam int MODE_LSTOP = 8;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam int MAIN_DRV = 0;
  localparam int MAIN_ERR = 4;
  localparam int ERR_PLIM = 2;
  localparam int ERR_NLIM = 3;
  localparam int ERR_FAULT = 4;
  localparam int ERR_EMG = 5;
  localparam int ERR_INDEX = 7;
  localparam int ERR_STATE_LSB = 8;
  localparam int END_PLIM = 12;
  localparam int END_NLIM = 13;
  localparam int END_FAULT = 14;
  localparam int END_EMG = 15;
  localparam logic [7:0] ERR_RST = 8'h00;
  localparam logic [3:0] END_RST = 4'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // execution state codes shown to software
  localparam logic [4:0] CODE_IDLE = 5'h00;
  localparam logic [4:0] CODE_S1 = 5'h03;
  localparam logic [4:0] CODE_S2_REV = 5'h08;
  localparam logic [4:0] CODE_S2_OUT = 5'h0C;
  localparam logic [4:0] CODE_S2_FIND = 5'h0F;
  localparam logic [4:0] CODE_S3 = 5'h14;
  localparam logic [4:0] CODE_S4 = 5'h19;

  typedef enum logic [2:0] {
    HS_IDLE, HS_S1, HS_S2_REV, HS_S2_OUT, HS_S2_FIND, HS_S3, HS_S4, HS_DECEL
  } hsrch_state_t;

  function automatic logic hsrch_mapped(input logic [4:0] a);
    hsrch_mapped = (a == HSRCH_CTRL_OFS) || (a == HSRCH_MODE_OFS) || (a == HSRCH_MAIN_OFS) ||
                   (a == HSRCH_ERR_OFS) || (a == HSRCH_END_OFS);
  endfunction : hsrch_mapped
endpackage : hsrch_pkg

// [hw/hsrch_reg_if.sv]
// register access path between the bus slave and the search core
`timescale 1ns/1ps
interface hsrch_reg_if #(parameter int AW = 5);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface : hsrch_reg_if

// [hw/hsrch_sync.sv]
// two flip-flop synchroniser for the sensor inputs
`timescale 1ns/1ps
module hsrch_sync #(
  parameter int W = 7
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : hsrch_sync

// [hw/hsrch_axil.sv]
// axi4-lite slave front end for the search registers
`timescale 1ns/1ps
module hsrch_axil
  import hsrch_pkg::*;
#(
  parameter int AW = HSRCH_AW
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  hsrch_reg_if.bus rb
);
  logic aw_got_ff, w_got_ff, bvalid_ff, awready_ff, wready_ff;
  logic arready_ff, rvalid_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic aw_hs, w_hs, do_wr, nxt_aw_got, nxt_w_got, nxt_bvalid;

  // ---------------------------------------------------------------
  // write channel: address and data in either order
  // ---------------------------------------------------------------
  assign aw_hs = s_awvalid && awready_ff;
  assign w_hs = s_wvalid && wready_ff;
  assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
  assign nxt_aw_got = (aw_got_ff || aw_hs) && !do_wr;
  assign nxt_w_got = (w_got_ff || w_hs) && !do_wr;
  assign nxt_bvalid = do_wr || (bvalid_ff && !s_bready);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= AXI_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      if (aw_hs) begin
        awaddr_ff <= s_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      if (do_wr) begin
        bresp_ff <= hsrch_mapped(awaddr_ff) ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= AXI_OKAY;
    end else if (s_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= hsrch_mapped(s_araddr) ? rb.rd_data : 32'h0000_0000;
      rresp_ff <= hsrch_mapped(s_araddr) ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_ff && s_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else begin
      arready_ff <= !rvalid_ff;
    end
  end

  assign rb.wr_en = do_wr && hsrch_mapped(awaddr_ff);
  assign rb.wr_addr = awaddr_ff;
  assign rb.wr_data = wdata_ff;
  assign rb.wr_strb = wstrb_ff;
  assign rb.rd_addr = s_araddr;
  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
endmodule : hsrch_axil

// [hw/hsrch_top.sv]
// one axis origin search sequencer with error detection and termination
`timescale 1ns/1ps
module hsrch_top
  import hsrch_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [HSRCH_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [HSRCH_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic drive_fault_input,
  input wire logic emergency_stop_input,
  input wire logic positive_limit_input,
  input wire logic negative_limit_input,
  input wire logic near_origin_input,
  input wire logic origin_input,
  input wire logic index_pulse_input,
  input wire logic motion_stopped,
  input wire logic offset_done,
  output logic pulse_run,
  output logic pulse_dir_minus,
  output logic fast_speed,
  output logic decel_active
);
  hsrch_reg_if #(.AW(HSRCH_AW)) rb ();
  hsrch_state_t state_ff, nxt_state;
  logic [8:0] mode_ff;
  logic [7:0] err_ff;
  logic [3:0] end_ff;
  logic [5:0] pend_ff, nxt_pend;
  logic drv_ff, sum_ff, run_ff, dir_ff, fast_ff, decel_ff;
  logic [6:0] sens;
  logic fault_s, emg_s, plim_s, nlim_s, near_s, origin_s, index_s;
  logic wr_ctrl, start_cmd, dstop_cmd, istop_cmd, clr_cmd, drive_cmd;
  logic term, active, live_lim, wipe;
  logic [5:0] cause;
  logic [2:0] go_step;

  // ---------------------------------------------------------------
  // bus and input synchronisation
  // ---------------------------------------------------------------
  hsrch_axil #(.AW(HSRCH_AW)) u_axil (
    .ref_clk(ref_clk), .nrst(nrst),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .rb(rb)
  );

  hsrch_sync #(.W(7)) u_sync (
    .ref_clk(ref_clk), .nrst(nrst),
    .din({drive_fault_input, emergency_stop_input, positive_limit_input,
          negative_limit_input, near_origin_input, origin_input, index_pulse_input}),
    .dout(sens)
  );
  assign {fault_s, emg_s, plim_s, nlim_s, near_s, origin_s, index_s} = sens;

  assign wr_ctrl = rb.wr_en && (rb.wr_addr == HSRCH_CTRL_OFS) && rb.wr_strb[0];
  assign start_cmd = wr_ctrl && rb.wr_data[CTRL_START];
  assign dstop_cmd = wr_ctrl && rb.wr_data[CTRL_DSTOP];
  assign istop_cmd = wr_ctrl && rb.wr_data[CTRL_ISTOP];
  assign clr_cmd = wr_ctrl && rb.wr_data[CTRL_CLR];
  assign drive_cmd = wr_ctrl && rb.wr_data[CTRL_DRIVE];
  assign active = (state_ff != HS_IDLE);
  assign wipe = clr_cmd || (start_cmd && !active);

  function automatic logic lim_of(input logic minus, input logic p, input logic n);
    lim_of = minus ? n : p;
  endfunction : lim_of

  // cause vector: {index, emg, fault, nlim, plim, unused}
  function automatic logic [5:0] lim_cause(input logic minus);
    lim_cause = minus ? 6'h04 : 6'h02;
  endfunction : lim_cause

  function automatic logic [4:0] code_of(input hsrch_state_t s);
    case (s)
      HS_S1: code_of = CODE_S1;
      HS_S2_REV: code_of = CODE_S2_REV;
      HS_S2_OUT: code_of = CODE_S2_OUT;
      HS_S2_FIND: code_of = CODE_S2_FIND;
      HS_S3: code_of = CODE_S3;
      HS_S4: code_of = CODE_S4;
      default: code_of = CODE_IDLE;
    endcase
  endfunction : code_of

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    go_step = 3'd0;
    term = 1'b0;
    cause = 6'h00;
    case (state_ff)
      HS_IDLE: begin
        if (start_cmd) begin
          go_step = 3'd1;
        end
      end
      HS_S1: begin
        if (near_s || lim_of(mode_ff[1], plim_s, nlim_s)) begin
          go_step = 3'd2;
        end
      end
      HS_S2_REV: begin
        if (origin_s) begin
          nxt_state = HS_S2_OUT;
        end else if (lim_of(!mode_ff[3], plim_s, nlim_s)) begin
          cause = lim_cause(!mode_ff[3]);
          term = 1'b1;
        end
      end
      HS_S2_OUT: begin
        if (!origin_s) begin
          nxt_state = HS_S2_FIND;
        end else if (lim_of(!mode_ff[3], plim_s, nlim_s)) begin
          cause = lim_cause(!mode_ff[3]);
          term = 1'b1;
        end
      end
      HS_S2_FIND: begin
        if (origin_s) begin
          go_step = 3'd3;
        end else if (lim_of(mode_ff[3], plim_s, nlim_s)) begin
          nxt_state = HS_S2_REV;
        end
      end
      HS_S3, HS_S4: begin
        if (state_ff == HS_S3 && index_s) begin
          go_step = 3'd4;
        end else if (state_ff == HS_S4 && offset_done) begin
          go_step = 3'd5;
        end else if (plim_s || nlim_s) begin
          cause = {3'h0, nlim_s, plim_s, 1'b0};
          if (mode_ff[MODE_LSTOP]) begin
            nxt_state = HS_DECEL;
          end else begin
            term = 1'b1;
          end
        end
      end
      HS_DECEL: begin
        if (motion_stopped) begin
          term = 1'b1;
        end
      end
      default: begin
        term = 1'b1;
      end
    endcase
    // skip disabled steps; near origin already active skips the fast step
    for (int k = 1; k <= 4; k++) begin
      if (go_step == 3'(k) && (!mode_ff[2*k-2] || (k == 1 && near_s))) begin
        go_step = 3'(k + 1);
      end
    end
    case (go_step)
      3'd1: nxt_state = HS_S1;
      3'd2: begin
        if (lim_of(mode_ff[3], plim_s, nlim_s)) begin
          nxt_state = HS_S2_REV;
        end else if (origin_s) begin
          nxt_state = HS_S2_OUT;
        end else begin
          nxt_state = HS_S2_FIND;
        end
      end
      3'd3: begin
        if (index_s) begin
          cause = 6'h20;
          term = 1'b1;
        end else begin
          nxt_state = HS_S3;
        end
      end
      3'd4: nxt_state = HS_S4;
      3'd5: term = 1'b1;
      default: begin
      end
    endcase
    if (active && (fault_s || emg_s)) begin
      cause = cause | {1'b0, emg_s, fault_s, 3'h0};
      term = 1'b1;
    end else if (active && istop_cmd) begin
      term = 1'b1;
    end else if (active && dstop_cmd && !term) begin
      nxt_state = HS_DECEL;
    end
    if (term) begin
      nxt_state = HS_IDLE;
    end
    nxt_pend = ((start_cmd && !active) ? 6'h00 : pend_ff) | cause;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff <= HS_IDLE;
      pend_ff <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      pend_ff <= term ? 6'h00 : nxt_pend;
    end
  end

  // ---------------------------------------------------------------
  // motion outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_ff <= 1'b0;
      dir_ff <= 1'b0;
      fast_ff <= 1'b0;
      decel_ff <= 1'b0;
    end else begin
      run_ff <= (nxt_state != HS_IDLE);
      decel_ff <= (nxt_state == HS_DECEL);
      fast_ff <= (nxt_state == HS_S1) || (nxt_state == HS_S4);
      case (nxt_state)
        HS_S1: dir_ff <= mode_ff[1];
        HS_S2_REV, HS_S2_OUT: dir_ff <= !mode_ff[3];
        HS_S2_FIND: dir_ff <= mode_ff[3];
        HS_S3: dir_ff <= mode_ff[5];
        HS_S4: dir_ff <= mode_ff[7];
        default: dir_ff <= dir_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_ff <= MODE_RST;
    end else if (rb.wr_en && rb.wr_addr == HSRCH_MODE_OFS) begin
      if (rb.wr_strb[0]) begin
        mode_ff[7:0] <= rb.wr_data[7:0];
      end
      if (rb.wr_strb[1]) begin
        mode_ff[8] <= rb.wr_data[8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      drv_ff <= 1'b0;
    end else if (term) begin
      drv_ff <= 1'b0;
    end else if (start_cmd && !active) begin
      drv_ff <= 1'b1;
    end
  end

  // set wins over any clear arriving in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      err_ff <= ERR_RST;
      end_ff <= END_RST;
    end else begin
      if (wipe) begin
        err_ff <= ERR_RST;
        end_ff <= END_RST;
      end else if (drive_cmd) begin
        err_ff[ERR_INDEX] <= 1'b0;
      end
      if (term) begin
        err_ff[ERR_PLIM] <= (err_ff[ERR_PLIM] && !wipe) | nxt_pend[1];
        err_ff[ERR_NLIM] <= (err_ff[ERR_NLIM] && !wipe) | nxt_pend[2];
        err_ff[ERR_FAULT] <= (err_ff[ERR_FAULT] && !wipe) | nxt_pend[3];
        err_ff[ERR_EMG] <= (err_ff[ERR_EMG] && !wipe) | nxt_pend[4];
        err_ff[ERR_INDEX] <= (err_ff[ERR_INDEX] && !wipe && !drive_cmd) | nxt_pend[5];
        end_ff <= (end_ff & {4{!wipe}}) | nxt_pend[4:1];
      end
    end
  end

  assign live_lim = ((state_ff == HS_S1) && lim_of(mode_ff[1], plim_s, nlim_s)) ||
                    ((state_ff == HS_S2_REV) && lim_of(mode_ff[3], plim_s, nlim_s));

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sum_ff <= 1'b0;
    end else begin
      sum_ff <= (|nxt_pend[5:1] && term) || (|err_ff && !(clr_cmd || start_cmd)) ||
                live_lim;
    end
  end

  always_comb begin
    rb.rd_data = 32'h0000_0000;
    case (rb.rd_addr)
      HSRCH_MODE_OFS: rb.rd_data[8:0] = mode_ff;
      HSRCH_MAIN_OFS: begin
        rb.rd_data[MAIN_DRV] = drv_ff;
        rb.rd_data[MAIN_ERR] = sum_ff;
      end
      HSRCH_ERR_OFS: rb.rd_data[ERR_STATE_LSB+4:0] = {code_of(state_ff), err_ff};
      HSRCH_END_OFS: rb.rd_data[END_EMG:END_PLIM] = end_ff;
      default: rb.rd_data = 32'h0000_0000;
    endcase
  end

  assign pulse_run = run_ff;
  assign pulse_dir_minus = dir_ff;
  assign fast_speed = fast_ff;
  assign decel_active = decel_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_fault_halt: assert property (active && fault_s |=>
    !run_ff && !drv_ff && err_ff[ERR_FAULT] && end_ff[END_FAULT - END_PLIM])
    else $error("drive fault did not halt the search");
  a_emg_halt: assert property (active && emg_s |=>
    state_ff == HS_IDLE && err_ff[ERR_EMG] && sum_ff)
    else $error("emergency stop did not halt the search");
  a_idx_limit: assert property (state_ff == HS_S3 && plim_s && !index_s && !fault_s &&
    !emg_s && !wr_ctrl && !mode_ff[MODE_LSTOP] |=> !drv_ff && err_ff[ERR_PLIM])
    else $error("limit in index step not reported");
  a_ofs_decel: assert property (state_ff == HS_S4 && nlim_s && !offset_done &&
    !fault_s && !emg_s && !wr_ctrl && mode_ff[MODE_LSTOP] |=> decel_ff && pend_ff[2])
    else $error("offset limit did not decelerate");
  a_index_early: assert property ($rose(err_ff[ERR_INDEX]) |-> !drv_ff && !run_ff &&
    state_ff == HS_IDLE)
    else $error("index error without termination");
  a_drv_idle: assert property ($fell(drv_ff) |-> state_ff == HS_IDLE && !run_ff)
    else $error("driving bit dropped while still moving");
  a_err_same: assert property (active && term && |nxt_pend[5:1] |=>
    !drv_ff && |err_ff && sum_ff)
    else $error("error bits not set with driving clear");
  a_abort_stop: assert property (active && istop_cmd |=> state_ff == HS_IDLE)
    else $error("instant stop did not abort the search");
  a_near_skip: assert property (!active && start_cmd && mode_ff[0] && near_s |=>
    state_ff != HS_S1)
    else $error("fast step not skipped");
  a_idx_clear: assert property (drive_cmd && !term |=> !err_ff[ERR_INDEX])
    else $error("index error not cleared");
endmodule : hsrch_top

// [bench/hsrch_drv_model.sv]
// drive side model answering stop and offset completion
`timescale 1ns/1ps
module hsrch_drv_model #(
  parameter int DLY = 3,
  parameter int OFS = 40
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pulse_run,
  input wire logic decel_active,
  output logic motion_stopped,
  output logic offset_done
);
  int dcnt_ff;
  int ocnt_ff;
  always_ff @(posedge ref_clk) begin
    dcnt_ff <= (!nrst || !decel_active) ? 0 : dcnt_ff + 1;
  end
  always_ff @(posedge ref_clk) begin
    ocnt_ff <= (!nrst || !pulse_run) ? 0 : ocnt_ff + 1;
  end
  // a ramp down takes some cycles, offset done comes a fixed run after pulses start
  assign motion_stopped = decel_active && (dcnt_ff >= DLY);
  assign offset_done = pulse_run && (ocnt_ff >= OFS);
endmodule : hsrch_drv_model

// [bench/tb_home_search_error_handling.sv]
// self-checking bench for the origin search error handler
`timescale 1ns/1ps
module tb_home_search_error_handling;
  import hsrch_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] s_awaddr = 5'h00, s_araddr = 5'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [6:0] sens = 7'h00;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [31:0] s_rdata, rd;
  logic motion_stopped, offset_done, pulse_run, pulse_dir_minus, fast_speed, decel_active;
  int n_errors = 0;
  int tests_run = 0;
  int tnum = 0;
  hsrch_top u_dut (.ref_clk, .nrst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .drive_fault_input(sens[6]),
    .emergency_stop_input(sens[5]), .positive_limit_input(sens[4]),
    .negative_limit_input(sens[3]), .near_origin_input(sens[2]), .origin_input(sens[1]),
    .index_pulse_input(sens[0]), .motion_stopped, .offset_done, .pulse_run,
    .pulse_dir_minus, .fast_speed, .decel_active);
  hsrch_drv_model u_model (.ref_clk, .nrst, .pulse_run, .decel_active, .motion_stopped,
    .offset_done);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tmo();
    chk("handshake", 32'h1, 32'h0);
    tally_and_finish();
  endtask : tmo
  // ---------------------------------------------------------------
  // bus access, one write or one read at a time
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    n = 0;
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    s_awvalid <= w;
    s_wvalid <= w;
    s_bready <= w;
    s_arvalid <= !w;
    s_rready <= !w;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
    end while (!(w ? s_bvalid : s_rvalid) && n < 50);
    s_bready <= 1'b0;
    s_rready <= 1'b0;
    rd = s_rdata;
    resp = w ? s_bresp : s_rresp;
    if (n >= 50) tmo();
  endtask : bus
  task automatic srch(input logic [8:0] md, input logic [6:0] pre, input logic [6:0] post,
      input logic [4:0] cmd, input logic [4:0] st, input logic [4:0] clr,
      input logic [15:0] ee, input logic [15:0] ce);
    int n;
    n = 0;
    tnum++;
    sens <= pre;
    bus(1'b1, HSRCH_MODE_OFS, {23'h0, md});
    bus(1'b0, HSRCH_MODE_OFS, 32'h0);
    chk("mode", {23'h0, md}, rd);
    bus(1'b1, HSRCH_CTRL_OFS, 32'h1);
    if (st != 5'h00) begin
      bus(1'b0, HSRCH_MAIN_OFS, 32'h0);
      chk("drv", 32'h1, rd & 32'h1);
      bus(1'b0, HSRCH_ERR_OFS, 32'h0);
      chk("state", {19'h0, st, 8'h00}, rd & 32'h1F00);
      chk("run", 32'h1, {31'h0, pulse_run});
      chk("fast", {31'h0, st == CODE_S1 || st == CODE_S4}, {31'h0, fast_speed});
      chk("dir", {31'h0, st == CODE_S2_OUT ? !md[3] : md[st == CODE_S1 ? 1 :
        st == CODE_S2_FIND ? 3 : st == CODE_S3 ? 5 : 7]}, {31'h0, pulse_dir_minus});
    end
    sens <= post;
    if (cmd != 5'h00) bus(1'b1, HSRCH_CTRL_OFS, {27'h0, cmd});
    do begin
      bus(1'b0, HSRCH_MAIN_OFS, 32'h0);
      n++;
    end while (rd[MAIN_DRV] !== 1'b0 && n < 100);
    if (n >= 100) tmo();
    chk("main", {27'h0, |ee, 4'h0}, rd);
    bus(1'b0, HSRCH_ERR_OFS, 32'h0);
    chk("err", {16'h0, ee}, rd);
    bus(1'b0, HSRCH_END_OFS, 32'h0);
    chk("end", {16'h0, ce}, rd);
    sens <= 7'h00;
    bus(1'b1, HSRCH_CTRL_OFS, {27'h0, clr});
    bus(1'b0, HSRCH_ERR_OFS, 32'h0);
    chk("clear", 32'h0, rd);
    $display("test %0d done", tnum);
  endtask : srch
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int a = 4; a <= 16; a += 4) begin
      bus(1'b0, a[4:0], 32'h0);
      chk("reset", 32'h0, rd);
    end
    bus(1'b0, 5'h14, 32'h0);
    chk("rresp", {30'h0, AXI_SLVERR}, {30'h0, resp});
    bus(1'b1, 5'h14, 32'h1);
    chk("bresp", {30'h0, AXI_SLVERR}, {30'h0, resp});
    $display("test reset done");
    srch(9'h010, 7'h01, 7'h00, 5'h00, 5'h00, 5'h10, 16'h0080, 16'h0);
    srch(9'h010, 7'h00, 7'h40, 5'h00, 5'h14, 5'h08, 16'h0010, 16'h4000);
    srch(9'h010, 7'h00, 7'h20, 5'h00, 5'h14, 5'h08, 16'h0020, 16'h8000);
    srch(9'h010, 7'h00, 7'h60, 5'h00, 5'h14, 5'h08, 16'h0030, 16'hC000);
    srch(9'h010, 7'h00, 7'h10, 5'h00, 5'h14, 5'h08, 16'h0004, 16'h1000);
    srch(9'h030, 7'h08, 7'h08, 5'h00, 5'h00, 5'h08, 16'h0008, 16'h2000);
    srch(9'h1C0, 7'h00, 7'h08, 5'h00, 5'h19, 5'h08, 16'h0008, 16'h2000);
    srch(9'h010, 7'h00, 7'h00, 5'h02, 5'h14, 5'h08, 16'h0, 16'h0);
    srch(9'h005, 7'h04, 7'h00, 5'h04, 5'h0F, 5'h08, 16'h0, 16'h0);
    srch(9'h040, 7'h00, 7'h00, 5'h00, 5'h19, 5'h08, 16'h0, 16'h0);
    srch(9'h005, 7'h00, 7'h18, 5'h00, 5'h03, 5'h08, 16'h0008, 16'h2000);
    srch(9'h004, 7'h02, 7'h0A, 5'h00, 5'h0C, 5'h08, 16'h0008, 16'h2000);
    tally_and_finish();
  end
endmodule : tb_home_search_error_handling
